// File: asfs_consts.svh
// Constants for the sample-ready and FIFO fill status block
`ifndef ASFS_CONSTS_SVH
`define ASFS_CONSTS_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define ASFS_ADDR_STATUS 8'h00
`define ASFS_ADDR_AXIS1_HI 8'h01
`define ASFS_ADDR_AXIS1_LO 8'h02
`define ASFS_ADDR_AXIS2_HI 8'h03
`define ASFS_ADDR_AXIS2_LO 8'h04
`define ASFS_ADDR_AXIS3_HI 8'h05
`define ASFS_ADDR_AXIS3_LO 8'h06
`define ASFS_ADDR_STEP 8'h01
`define ASFS_ADDR_FAST_STEP 8'h02

// ----------------------------------------------------------------
// Field values and reset values
// ----------------------------------------------------------------
`define ASFS_FMODE_OFF 2'h0
`define ASFS_FMODE_TRIG 2'h3
`define ASFS_STATUS_RST 8'h00
`define ASFS_CNT_RST 6'h00
`define ASFS_BYTE_ZERO 8'h00
`define ASFS_AXES_ALL 3'h7
`define ASFS_AXES_NONE 3'h0
`define ASFS_LO_PAD 2'h0

// ----------------------------------------------------------------
// Axis one-hot codes and byte field positions in a 14-bit sample
// ----------------------------------------------------------------
`define ASFS_AXIS1_HOT 3'h1
`define ASFS_AXIS2_HOT 3'h2
`define ASFS_AXIS3_HOT 3'h4
`define ASFS_HI_MSB 13
`define ASFS_HI_LSB 6
`define ASFS_LO_MSB 5
`define ASFS_LO_LSB 0

`endif

// File: asfs_pkg.sv
// Types shared by the sample-ready and FIFO fill status block
`default_nettype none
package asfs_pkg;

    // ----------------------------------------------------------------
    // Sample data from the acquisition core, 14-bit per axis
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [13:0] axis3;
        logic [13:0] axis2;
        logic [13:0] axis1;
    } asfs_sample_s;

    // ----------------------------------------------------------------
    // FIFO status from the FIFO core
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0] mode;
        logic [5:0] wmrk;
        logic [5:0] cnt;
        logic ovf;
        logic trig;
        logic push;
    } asfs_fifo_s;

    // ----------------------------------------------------------------
    // Complete state of the status block
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [2:0] dr;
        logic [2:0] ow;
        logic zyxdr;
        logic zyxow;
        logic [2:0] hi_seen;
        logic src_fifo;
        logic [5:0] cnt;
        logic ovf;
        logic wflag;
        logic [7:0] rd_data;
        logic rd_valid;
    } asfs_state_s;

endpackage
`default_nettype wire

// File: asfs_status.sv
// Status register at address zero with auto-increment burst reads
`timescale 1ns/1ps
`default_nettype none
`include "asfs_consts.svh"

module asfs_status (
    input wire logic clk, // 100 MHz device clock
    input wire logic nrst, // Async reset, active low
    input wire logic rd_start, // Start of read at rd_addr
    input wire logic [7:0] rd_addr, // Start address of a read
    input wire logic rd_next, // Next byte of a burst
    input wire logic bus_stop, // Two-wire stop seen
    input wire logic spi_sel, // Four-wire serial mode
    input wire logic fast_read, // 8-bit output mode
    input wire logic [2:0] acq_done, // Per-axis acquisition done
    input wire asfs_pkg::asfs_sample_s sample, // Current sample or FIFO head
    input wire asfs_pkg::asfs_fifo_s fifo, // FIFO core status
    output logic [7:0] rd_data, // Byte read
    output logic rd_valid, // Read byte strobe
    output logic [7:0] cur_addr, // Auto-increment address
    output logic [7:0] ready_status, // Data-ready form snapshot
    output logic src_fifo // FIFO interrupt source bit
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------

    // Axis whose high byte sits at an address, one-hot
    function automatic logic [2:0] hi_axis(input logic [7:0] a);
        logic [2:0] r;
        r = `ASFS_AXES_NONE;
        case (a)
            `ASFS_ADDR_AXIS1_HI: r = `ASFS_AXIS1_HOT;
            `ASFS_ADDR_AXIS2_HI: r = `ASFS_AXIS2_HOT;
            `ASFS_ADDR_AXIS3_HI: r = `ASFS_AXIS3_HOT;
            default: r = `ASFS_AXES_NONE;
        endcase
        return r;
    endfunction

    // Next burst address; fast mode skips low bytes and wraps to status after axis3 high
    function automatic logic [7:0] next_addr(input logic [7:0] a, input logic fast);
        logic [7:0] r;
        r = a + `ASFS_ADDR_STEP;
        if (fast) begin
            if (a == `ASFS_ADDR_STATUS) begin
                r = `ASFS_ADDR_AXIS1_HI;
            end else if (a >= `ASFS_ADDR_AXIS3_HI) begin
                r = `ASFS_ADDR_STATUS;
            end else begin
                r = a + `ASFS_ADDR_FAST_STEP;
            end
        end
        return r;
    endfunction

    // High byte of a 14-bit value, left justified
    function automatic logic [7:0] hi_byte(input logic [13:0] d);
        return d[`ASFS_HI_MSB:`ASFS_HI_LSB];
    endfunction

    // Low byte of a 14-bit value, padded below
    function automatic logic [7:0] lo_byte(input logic [13:0] d);
        return {d[`ASFS_LO_MSB:`ASFS_LO_LSB], `ASFS_LO_PAD};
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    asfs_pkg::asfs_state_s st_reg;
    asfs_pkg::asfs_state_s st_next;
    logic fifo_on;
    logic rd_go;
    logic [7:0] acc_addr;
    logic [2:0] hit;
    logic [7:0] ready_form;
    logic [7:0] fifo_form;
    logic [7:0] status_byte;
    logic [7:0] byte_val;

    // ----------------------------------------------------------------
    // Status forms
    // ----------------------------------------------------------------

    // Decode of the two status views
    always_comb begin
        fifo_on = (fifo.mode != `ASFS_FMODE_OFF);
        ready_form = {st_reg.zyxow, st_reg.ow[2], st_reg.ow[1], st_reg.ow[0],
                      st_reg.zyxdr, st_reg.dr[2], st_reg.dr[1], st_reg.dr[0]};
        // FIFO form layout, count in low bits
        fifo_form = {st_reg.ovf, st_reg.wflag, st_reg.cnt};
        status_byte = fifo_on ? fifo_form : ready_form;
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------

    // Byte selection; unmapped addresses read as zero
    always_comb begin
        rd_go = rd_start | rd_next;
        acc_addr = rd_start ? rd_addr : st_reg.addr;
        hit = hi_axis(acc_addr);
        // status directly below the axis data
        case (acc_addr)
            `ASFS_ADDR_STATUS: byte_val = status_byte;
            `ASFS_ADDR_AXIS1_HI: byte_val = hi_byte(sample.axis1);
            `ASFS_ADDR_AXIS1_LO: byte_val = lo_byte(sample.axis1);
            `ASFS_ADDR_AXIS2_HI: byte_val = hi_byte(sample.axis2);
            `ASFS_ADDR_AXIS2_LO: byte_val = lo_byte(sample.axis2);
            `ASFS_ADDR_AXIS3_HI: byte_val = hi_byte(sample.axis3);
            `ASFS_ADDR_AXIS3_LO: byte_val = lo_byte(sample.axis3);
            default: byte_val = `ASFS_BYTE_ZERO;
        endcase
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------

    // Clears from reads first, then hardware sets so a set wins
    always_comb begin
        st_next = st_reg;
        st_next.rd_valid = 1'b0;

        st_next.cnt = fifo.cnt;
        st_next.ovf = fifo.ovf;
        // trigger mode reuses the watermark position
        if (fifo.mode == `ASFS_FMODE_TRIG) begin
            st_next.wflag = fifo.trig;
        end else begin
            // level while count at or above watermark
            st_next.wflag = (fifo.cnt >= fifo.wmrk);
        end

        if (rd_go) begin
            st_next.rd_data = byte_val;
            st_next.rd_valid = 1'b1;
            st_next.addr = next_addr(acc_addr, fast_read);
            // per-axis overwrite clears on high-byte read
            st_next.ow = st_reg.ow & ~hit;
            // per-axis ready clears on high-byte read
            st_next.dr = st_reg.dr & ~hit;
            st_next.hi_seen = st_reg.hi_seen | hit;
            // combined flags clear once every high byte was read
            if ((st_reg.hi_seen | hit) == `ASFS_AXES_ALL) begin
                st_next.zyxdr = 1'b0;
                st_next.zyxow = 1'b0;
                st_next.hi_seen = `ASFS_AXES_NONE;
            end
            // FIFO form read drops the interrupt source only
            if (fifo_on && acc_addr == `ASFS_ADDR_STATUS) begin
                st_next.src_fifo = 1'b0;
            end
        end

        // stop rewinds address on two-wire bus only
        if (bus_stop && !spi_sel) begin
            st_next.addr = `ASFS_ADDR_STATUS;
        end

        // Overwrite judged after same-cycle reads, so a read just in time counts
        // overwrite when previous axis value unread
        // any axis overwrite marks the combined flag
        if ((acq_done & st_next.dr) != `ASFS_AXES_NONE) begin
            st_next.ow = st_next.ow | (acq_done & st_next.dr);
            st_next.zyxow = 1'b1;
        end
        st_next.dr = st_next.dr | acq_done;
        if (acq_done != `ASFS_AXES_NONE) begin
            st_next.zyxdr = 1'b1;
        end

        // next sample into FIFO raises the source again
        if (fifo_on && fifo.push) begin
            st_next.src_fifo = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------

    // All flags and counters reset to zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_reg.addr <= `ASFS_ADDR_STATUS;
            st_reg.dr <= `ASFS_AXES_NONE;
            st_reg.ow <= `ASFS_AXES_NONE;
            st_reg.zyxdr <= 1'b0;
            st_reg.zyxow <= 1'b0;
            st_reg.hi_seen <= `ASFS_AXES_NONE;
            st_reg.src_fifo <= 1'b0;
            st_reg.cnt <= `ASFS_CNT_RST;
            st_reg.ovf <= 1'b0;
            st_reg.wflag <= 1'b0;
            st_reg.rd_data <= `ASFS_STATUS_RST;
            st_reg.rd_valid <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs, all straight from the state flops
    // ----------------------------------------------------------------
    assign rd_data = st_reg.rd_data;
    assign rd_valid = st_reg.rd_valid;
    assign cur_addr = st_reg.addr;
    assign src_fifo = st_reg.src_fifo;
    // Flop fields only; no logic between state and pins
    assign ready_status = {st_reg.zyxow, st_reg.ow, st_reg.zyxdr, st_reg.dr};

endmodule
`default_nettype wire

// File: asfs_status_sva.sv
// Port assertions for the status block
`timescale 1ns/1ps
`default_nettype none
module asfs_status_sva (
    input wire logic clk, // Clock
    input wire logic nrst, // Reset, active low
    input wire logic rd_start, // Read start
    input wire logic [7:0] rd_addr, // Start address
    input wire logic rd_next, // Burst step
    input wire logic bus_stop, // Stop seen
    input wire logic spi_sel, // Four-wire mode
    input wire logic fast_read, // 8-bit mode
    input wire logic [2:0] acq_done, // Acquisitions
    input wire asfs_pkg::asfs_fifo_s fifo, // FIFO status
    input wire logic [7:0] rd_data, // Read byte
    input wire logic rd_valid, // Read strobe
    input wire logic [7:0] cur_addr, // Burst address
    input wire logic [7:0] ready_status, // Ready form
    input wire logic src_fifo // FIFO source bit
);
    // ----
    // Helpers and properties
    // ----
    // Expected FIFO form; judged two edges late for the snapshot lag
    logic [7:0] fexp;
    logic rd0;
    logic nxt;
    assign fexp = {fifo.ovf, (fifo.mode == 2'h3) ? fifo.trig : (fifo.cnt >= fifo.wmrk), fifo.cnt};
    assign rd0 = rd_start && rd_addr == 8'h00 && acq_done == 3'h0;
    assign nxt = rd_next && !rd_start && !bus_stop;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_hi(a); nxt && fast_read && cur_addr == a && acq_done == 3'h0; endsequence
    sequence s_hi3; s_hi(8'h01) ##1 s_hi(8'h03) ##1 s_hi(8'h05); endsequence
    property p_ans; (rd_start || rd_next) |=> rd_valid; endproperty
    a_ans: assert property (p_ans) else $error("read not answered");
    property p_drf; rd0 && fifo.mode == 2'h0 |=> rd_data == $past(ready_status); endproperty
    a_drf: assert property (p_drf) else $error("ready form wrong");
    property p_ff; rd0 && fifo.mode != 2'h0 && $stable(fifo) && $past(nrst) |=> rd_data == $past(fexp, 2); endproperty
    a_ff: assert property (p_ff) else $error("fifo form wrong");
    property p_hclr; rd_start && rd_addr == 8'h01 && !acq_done[0] |=> !ready_status[0] && !ready_status[4]; endproperty
    a_hclr: assert property (p_hclr) else $error("axis flags kept");
    property p_set; acq_done[1] |=> ready_status[1] && ready_status[3]; endproperty
    a_set: assert property (p_set) else $error("ready not set");
    property p_ow; acq_done[2] && ready_status[2] && !rd_start && !rd_next |=> ready_status[6] && ready_status[7]; endproperty
    a_ow: assert property (p_ow) else $error("overwrite not set");
    property p_zyx; s_hi3 |=> !ready_status[3] && !ready_status[7]; endproperty
    a_zyx: assert property (p_zyx) else $error("combined flags kept");
    property p_inc; nxt && !fast_read |=> cur_addr == $past(cur_addr) + 8'h01; endproperty
    a_inc: assert property (p_inc) else $error("address not stepped");
    property p_stop; bus_stop && !spi_sel |=> cur_addr == 8'h00; endproperty
    a_stop: assert property (p_stop) else $error("stop kept address");
    property p_keep; bus_stop && spi_sel && !rd_start && !rd_next |=> $stable(cur_addr); endproperty
    a_keep: assert property (p_keep) else $error("address lost");
    property p_src; rd0 && fifo.mode != 2'h0 && !fifo.push |=> !src_fifo; endproperty
    a_src: assert property (p_src) else $error("source not cleared");
    property p_push; fifo.push && fifo.mode != 2'h0 |=> src_fifo; endproperty
    a_push: assert property (p_push) else $error("source not set");
endmodule
bind asfs_status asfs_status_sva chk_u (.clk, .nrst, .rd_start, .rd_addr, .rd_next, .bus_stop, .spi_sel,
    .fast_read, .acq_done, .fifo, .rd_data, .rd_valid, .cur_addr, .ready_status, .src_fifo);
`default_nettype wire

// File: asfs_host.sv
// Host model issuing register reads
`timescale 1ns/1ps
`default_nettype none
module asfs_host (
    input wire logic clk, // Device clock
    input wire logic [7:0] rd_data, // Read byte
    input wire logic rd_valid, // Read strobe
    output logic rd_start, // Read start
    output logic [7:0] rd_addr, // Start address
    output logic rd_next, // Burst step
    output logic bus_stop // Stop condition
);
    logic [7:0] got [$];
    int miss = 0;
    // Idle bus until the first request
    initial begin
        rd_start = 1'b0;
        rd_addr = 8'h00;
        rd_next = 1'b0;
        bus_stop = 1'b0;
    end
    // burst, one step every cycle after the start
    task automatic burst(input logic [7:0] a, input int n);
        got.delete();
        @(negedge clk);
        rd_start = 1'b1;
        rd_addr = a;
        for (int k = 1; k <= n; k++) begin
            @(negedge clk);
            // answer one cycle after each request
            if (rd_valid !== 1'b1) begin
                miss++;
                $display("CHECK FAILED t=%0t rd_valid=%h exp=%h", $time, rd_valid, 1'b1);
            end
            got.push_back(rd_data);
            rd_start = 1'b0;
            rd_next = (k < n);
        end
    endtask
    task automatic stop();
        @(negedge clk);
        bus_stop = 1'b1;
        @(negedge clk);
        bus_stop = 1'b0;
    endtask
endmodule
`default_nettype wire

// File: test_accel_sample_fifo_status.sv
// Self-checking bench for the status block
`timescale 1ns/1ps
`default_nettype none
module test_accel_sample_fifo_status;
    logic clk, nrst, spi_sel, fast_read, rd_start, rd_next, bus_stop, rd_valid, src_fifo;
    logic [2:0] acq_done;
    logic [7:0] rd_addr, rd_data, cur_addr, ready_status;
    asfs_pkg::asfs_sample_s sample;
    asfs_pkg::asfs_fifo_s fifo;
    int error_cnt = 0;
    int checked = 0;
    asfs_status dut_u (.clk, .nrst, .rd_start, .rd_addr, .rd_next, .bus_stop, .spi_sel, .fast_read,
        .acq_done, .sample, .fifo, .rd_data, .rd_valid, .cur_addr, .ready_status, .src_fifo);
    asfs_host host_u (.clk, .rd_data, .rd_valid, .rd_start, .rd_addr, .rd_next, .bus_stop);
    // ----
    // Shared tasks
    // ----
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic acq(input logic [2:0] m);
        @(negedge clk);
        acq_done = m;
        @(negedge clk);
        acq_done = 3'h0;
        @(negedge clk);
    endtask
    // Reset values, then a full burst of status and axis data
    task automatic t_burst();
        chk(ready_status, 8'h00);
        chk({7'h00, src_fifo}, 8'h00);
        chk(cur_addr, 8'h00);
        host_u.burst(8'h00, 7);
        chk(host_u.got[0], 8'h00);
        for (int i = 0; i < 3; i++) begin
            chk(host_u.got[2*i+1], sample[14*i+6 +: 8]);
            chk(host_u.got[2*i+2], {sample[14*i +: 6], 2'h0});
        end
    endtask
    // Flags set, overwrite, per-axis clear, combined clear in 8-bit mode
    task automatic t_flags();
        acq(3'h7);
        host_u.burst(8'h00, 1);
        chk(host_u.got[0], 8'h0f);
        acq(3'h5);
        chk(ready_status, 8'hdf);
        host_u.burst(8'h01, 1);
        chk(ready_status, 8'hce);
        fast_read = 1'b1;
        host_u.burst(8'h00, 4);
        chk(host_u.got[0], 8'hce);
        chk(host_u.got[3], sample.axis3[13:6]);
        chk(ready_status, 8'h00);
        chk(cur_addr, 8'h00);
        fast_read = 1'b0;
    endtask
    // FIFO form over modes, counts and watermark boundaries
    task automatic t_fifo();
        asfs_pkg::asfs_fifo_s ft [4] = '{'{2'h1, 6'h14, 6'h14, 1'b1, 1'b0, 1'b1}, '{2'h2, 6'h21, 6'h20, 1'b0, 1'b0, 1'b1},
            '{2'h3, 6'h01, 6'h20, 1'b0, 1'b0, 1'b1}, '{2'h3, 6'h3f, 6'h00, 1'b0, 1'b1, 1'b1}};
        logic [7:0] e;
        foreach (ft[i]) begin
            e = {ft[i].ovf, (ft[i].mode == 2'h3) ? ft[i].trig : (ft[i].cnt >= ft[i].wmrk), ft[i].cnt};
            @(negedge clk);
            fifo = ft[i];
            @(negedge clk);
            fifo.push = 1'b0;
            @(negedge clk);
            chk({7'h00, src_fifo}, 8'h01);
            host_u.burst(8'h00, 1);
            chk(host_u.got[0], e);
            chk({7'h00, src_fifo}, 8'h00);
        end
        fifo = '0;
    endtask
    // Stop handling in both bus modes, and an unmapped read
    task automatic t_stop();
        host_u.burst(8'h02, 2);
        chk(cur_addr, 8'h04);
        host_u.stop();
        chk(cur_addr, 8'h00);
        host_u.burst(8'h02, 2);
        spi_sel = 1'b1;
        host_u.stop();
        chk(cur_addr, 8'h04);
        spi_sel = 1'b0;
        host_u.burst(8'h07, 1);
        chk(host_u.got[0], 8'h00);
    endtask
    task automatic final_report();
        error_cnt += host_u.miss;
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ----
    // Clock, stimulus, watchdog
    // ----
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        nrst = 1'b0;
        spi_sel = 1'b0;
        fast_read = 1'b0;
        acq_done = 3'h0;
        fifo = '0;
        sample = {14'h3a5c, 14'h1234, 14'h2e81};
        repeat (4) @(negedge clk);
        nrst = 1'b1;
        t_burst();
        t_flags();
        t_fifo();
        t_stop();
        final_report();
    end
    // Whole run needs about 60 cycles
    initial begin
        #20000;
        error_cnt++;
        final_report();
    end
endmodule
`default_nettype wire
